// ==== common/fcc_defines.svh ====
// Register offsets, field positions, command codes and timing figures
`ifndef FCC_DEFINES_SVH
`define FCC_DEFINES_SVH

`define FCC_A_STATUS 8'h00
`define FCC_A_MODE 8'h04
`define FCC_A_CMD 8'h08
`define FCC_A_DATA 8'h0C
`define FCC_A_ADDR 8'h10
`define FCC_A_SIGN 8'h14
`define FCC_A_PROT_P 8'h18
`define FCC_A_PROT_H 8'h1C

`define FCC_STA_DONE 0
`define FCC_STA_FAIL 1
`define FCC_STA_BUSY 2
`define FCC_STA_IRQ 3
`define FCC_STA_BURST 5
`define FCC_MOD_IRQEN 4

`define FCC_CMD_NULL 8'h00
`define FCC_CMD_READ 8'h01
`define FCC_CMD_WRITE 8'h02
`define FCC_CMD_ERWR 8'h03
`define FCC_CMD_VERIFY 8'h04
`define FCC_CMD_ERASE 8'h05
`define FCC_CMD_MASS 8'h06
`define FCC_CMD_BREAD 8'h07
`define FCC_CMD_BWRITE 8'h08
`define FCC_CMD_BERWR 8'h09
`define FCC_CMD_BSTOP 8'h0A
`define FCC_CMD_SIGN 8'h0B
`define FCC_CMD_PROTECT 8'h0C
`define FCC_CMD_PING 8'h0F

`define FCC_MASS_KEY 16'h0006
`define FCC_USER_TOP 16'hF800
`define FCC_KERNEL_GRP 5'h1F
`define FCC_BURST_MAX 4'h8
`define FCC_RST_CMD 8'h07
`define FCC_RST_PROT 32'hFFFFFFFF

`define FCC_CLK_MHZ 250
`define FCC_T_PROG_US 20
`define FCC_T_ERASE_MS 20
`define FCC_T_MASS_MS 2480
`define FCC_SIGN_CYC 32778
`define FCC_READ_CYC 2

`endif

// ==== common/fcc_pkg.sv ====
// Types of the flash command controller
package fcc_pkg;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_READ = 3'h1,
    ST_ERASE = 3'h3,
    ST_PROG = 3'h2,
    ST_MASS = 3'h6,
    ST_SIGN = 3'h4
  } fcc_state_t;

  typedef enum logic [1:0] {
    FOP_READ = 2'h0,
    FOP_PROG = 2'h1,
    FOP_ERASE = 2'h2,
    FOP_MASS = 2'h3
  } fcc_fop_t;

  typedef struct packed {
    fcc_state_t st;
    logic [7:0] op;
    logic [7:0] cmd;
    logic [15:0] data;
    logic [15:0] addr;
    logic [7:0] mode;
    logic [23:0] sign;
    logic [31:0] prot_p;
    logic [31:0] prot_h;
    logic committed;
    logic done;
    logic fail;
    logic irqst;
    logic [1:0] guard;
    logic [31:0] cnt;
    logic [3:0] bcnt;
    logic berased;
    logic [15:0] saddr;
    logic pready;
    logic [31:0] prdata;
    logic pslverr;
    logic fl_en;
    fcc_fop_t fl_op;
    logic [15:0] fl_addr;
    logic [15:0] fl_wdata;
    logic irq;
  } fcc_regs_t;

endpackage

// ==== rtl/fcc_flash_command_controller.sv ====
// Flash command sequencer with APB register file
//
// Our own choices: the register offsets and register access over APB.
`timescale 1ns/1ps
`default_nettype none
`include "fcc_defines.svh"
module fcc_flash_command_controller
  import fcc_pkg::*;
#(
  parameter int unsigned PROG_CYC = `FCC_T_PROG_US * `FCC_CLK_MHZ,
  parameter int unsigned ERASE_CYC = `FCC_T_ERASE_MS * 1000 * `FCC_CLK_MHZ,
  parameter int unsigned MASS_CYC = `FCC_T_MASS_MS * 1000 * `FCC_CLK_MHZ,
  parameter int unsigned SIGN_CYC = `FCC_SIGN_CYC
) (
  input wire logic mclk_i,
  input wire logic rstn_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  output logic fl_en_o,
  output logic [1:0] fl_op_o,
  output logic [15:0] fl_addr_o,
  output logic [15:0] fl_wdata_o,
  input wire logic [15:0] fl_rdata_i,
  output logic irq_o
);

  localparam logic [31:0] READ_CNT = 32'(`FCC_READ_CYC);
  fcc_regs_t r;
  fcc_regs_t n;
  logic acc_w;
  logic wdone_w;
  logic [31:0] eff_prot_w;
  logic [32:0] rd_w;
  assign acc_w = psel_i & penable_i & ~r.pready;
  assign wdone_w = psel_i & penable_i & r.pready & pwrite_i;
  assign eff_prot_w = r.prot_p & r.prot_h;

  function automatic logic wr_ok(input logic [15:0] a, input logic [31:0] p);
    return (a[15:11] != `FCC_KERNEL_GRP) && p[a[15:11]];
  endfunction
  function automatic logic rd_blk(input logic [15:0] a, input logic [31:0] p);
    return !p[31] && (a < `FCC_USER_TOP);
  endfunction

  // Completion event, with interrupt status when enabled
  function automatic fcc_regs_t finish(input fcc_regs_t s);
    s.st = ST_IDLE;
    s.fl_en = 1'b0;
    s.done = 1'b1;
    if (s.mode[`FCC_MOD_IRQEN]) begin
      s.irqst = 1'b1;
    end
    if (s.op <= `FCC_CMD_MASS) begin
      s.cmd = `FCC_RST_CMD;
    end
    return s;
  endfunction
  // Refused command completes as a failure
  function automatic fcc_regs_t abort(input fcc_regs_t s);
    s = finish(s);
    s.fail = 1'b1;
    return s;
  endfunction
  // Starts a timed flash operation
  function automatic fcc_regs_t launch(input fcc_regs_t s,
      input fcc_state_t st, input logic [31:0] c, input fcc_fop_t fop);
    s.st = st;
    s.cnt = c;
    s.fl_en = 1'b1;
    s.fl_op = fop;
    s.fl_addr = s.addr;
    s.fl_wdata = s.data;
    return s;
  endfunction
  // Read mux, top bit flags an unmapped address
  function automatic logic [32:0] rd_mux(input fcc_regs_t s,
      input logic [7:0] a);
    logic burst;
    burst = (s.cmd >= `FCC_CMD_BREAD) && (s.cmd <= `FCC_CMD_BERWR);
    if (a == `FCC_A_STATUS) begin
      return {1'b0, 26'h0, burst, 1'b0, s.irqst, s.st != ST_IDLE,
              s.fail, s.done};
    end else if (a == `FCC_A_MODE) begin
      return {1'b0, 24'h0, s.mode};
    end else if (a == `FCC_A_CMD) begin
      return {1'b0, 24'h0, s.cmd};
    end else if (a == `FCC_A_DATA) begin
      return {1'b0, 16'h0, s.data};
    end else if (a == `FCC_A_ADDR) begin
      return {1'b0, 16'h0, s.addr};
    end else if (a == `FCC_A_SIGN) begin
      return {1'b0, 8'h0, s.sign};
    end else if (a == `FCC_A_PROT_P) begin
      return {1'b0, s.prot_p};
    end else if (a == `FCC_A_PROT_H) begin
      return {1'b0, s.prot_h};
    end else begin
      return {1'b1, 32'h0};
    end
  endfunction
  assign rd_w = rd_mux(r, paddr_i);
  always_comb begin
    n = r;
    // APB access phase: answer one cycle after penable
    n.pready = acc_w;
    if (acc_w) begin
      n.pslverr = rd_w[32];
      if (!pwrite_i) begin
        n.prdata = rd_w[31:0];
        if (paddr_i == `FCC_A_STATUS) begin
          n.done = 1'b0;
          n.fail = 1'b0;
          n.irqst = 1'b0;
        end
      end
    end
    if (r.st != ST_IDLE) begin
      n.cnt = r.cnt - 32'h1;
    end
    case (r.st)
      ST_READ: begin
        if (r.cnt == 32'h1) begin
          n = finish(n);
          if (r.op == `FCC_CMD_READ) begin
            n.data = fl_rdata_i;
            n.guard = 2'h1;
          end else if (fl_rdata_i != r.data) begin
            n.fail = 1'b1;
          end
        end
      end
      ST_ERASE: begin
        if (r.cnt == 32'h1) begin
          if (r.op == `FCC_CMD_ERASE) begin
            n = finish(n);
          end else begin
            n.st = ST_PROG;
            n.cnt = 32'(PROG_CYC);
            n.fl_op = FOP_PROG;
            n.berased = 1'b1;
          end
        end
      end
      ST_PROG: begin
        if (r.cnt == 32'h1) begin
          n = finish(n);
          if (r.op == `FCC_CMD_BWRITE || r.op == `FCC_CMD_BERWR) begin
            n.addr = r.addr + 16'h2;
            n.bcnt = r.bcnt + 4'h1;
            if (r.bcnt + 4'h1 == `FCC_BURST_MAX) begin
              n.cmd = `FCC_CMD_BREAD;
            end
          end
        end
      end
      ST_MASS: begin
        if (r.cnt == 32'h1) begin
          n = finish(n);
          n.prot_p = `FCC_RST_PROT;
          n.committed = 1'b0;
        end
      end
      ST_SIGN: begin
        n.sign = {r.sign[22:0], r.sign[23]} ^ {8'h0, fl_rdata_i};
        n.fl_addr = r.saddr;
        n.saddr = r.saddr + 16'h2;
        if (r.cnt == 32'h1) begin
          n = finish(n);
        end
      end
      default: ;
    endcase
    if (wdone_w && r.st == ST_IDLE) begin
      if (paddr_i == `FCC_A_MODE) begin
        n.mode = pwdata_i[7:0];
      end else if (paddr_i == `FCC_A_ADDR) begin
        n.addr = pwdata_i[15:0];
      end else if (paddr_i == `FCC_A_PROT_P) begin
        if (!r.committed) begin
          n.prot_p = pwdata_i;
        end
      end else if (paddr_i == `FCC_A_PROT_H) begin
        n.prot_h = pwdata_i;
      end else if (paddr_i == `FCC_A_DATA) begin
        n.data = pwdata_i[15:0];
        if ((r.cmd == `FCC_CMD_BWRITE || r.cmd == `FCC_CMD_BERWR) &&
            r.bcnt < `FCC_BURST_MAX) begin
          n.op = r.cmd;
          if (!wr_ok(r.addr, eff_prot_w)) begin
            n = abort(n);
          end else if (r.cmd == `FCC_CMD_BERWR && !r.berased) begin
            n = launch(n, ST_ERASE, 32'(ERASE_CYC), FOP_ERASE);
          end else begin
            n = launch(n, ST_PROG, 32'(PROG_CYC), FOP_PROG);
          end
        end
      end else if (paddr_i == `FCC_A_CMD) begin
        n.cmd = pwdata_i[7:0];
        n.op = pwdata_i[7:0];
        n.guard = 2'h0;
        case (pwdata_i[7:0])
          `FCC_CMD_NULL: begin
            n.cmd = `FCC_RST_CMD;
          end
          `FCC_CMD_READ, `FCC_CMD_VERIFY: begin
            if (pwdata_i[7:0] == `FCC_CMD_VERIFY && r.guard == 2'h1) begin
              n.guard = 2'h2;
            end
            if (rd_blk(r.addr, eff_prot_w)) begin
              n = abort(n);
            end else begin
              n = launch(n, ST_READ, READ_CNT, FOP_READ);
            end
          end
          `FCC_CMD_WRITE, `FCC_CMD_ERWR, `FCC_CMD_ERASE: begin
            if (!wr_ok(r.addr, eff_prot_w)) begin
              n = abort(n);
            end else if (pwdata_i[7:0] == `FCC_CMD_WRITE) begin
              n = launch(n, ST_PROG, 32'(PROG_CYC), FOP_PROG);
            end else begin
              n = launch(n, ST_ERASE, 32'(ERASE_CYC), FOP_ERASE);
            end
          end
          `FCC_CMD_MASS: begin
            if (r.guard == 2'h2 && r.data == `FCC_MASS_KEY) begin
              n = launch(n, ST_MASS, 32'(MASS_CYC), FOP_MASS);
            end else begin
              n = abort(n);
            end
          end
          `FCC_CMD_BWRITE, `FCC_CMD_BERWR: begin
            n.bcnt = 4'h0;
            n.berased = 1'b0;
          end
          `FCC_CMD_BSTOP: begin
            n.cmd = `FCC_CMD_BREAD;
            n = finish(n);
          end
          `FCC_CMD_SIGN: begin
            if (!eff_prot_w[31]) begin
              n = abort(n);
            end else begin
              n = launch(n, ST_SIGN, 32'(SIGN_CYC), FOP_READ);
              n.fl_addr = 16'h0;
              n.saddr = 16'h2;
              n.sign = 24'h0;
            end
          end
          `FCC_CMD_PROTECT: begin
            if (r.committed) begin
              n = abort(n);
            end else begin
              n.committed = 1'b1;
              n = finish(n);
            end
          end
          `FCC_CMD_PING: begin
            n = finish(n);
          end
          default: ;
        endcase
      end
    end
    n.irq = n.irqst;
  end

  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      r <= '0;
      r.cmd <= `FCC_RST_CMD;
      r.prot_p <= `FCC_RST_PROT;
      r.prot_h <= `FCC_RST_PROT;
    end else begin
      r <= n;
    end
  end

  assign prdata_o = r.prdata;
  assign pready_o = r.pready;
  assign pslverr_o = r.pslverr;
  assign fl_en_o = r.fl_en;
  assign fl_op_o = r.fl_op;
  assign fl_addr_o = r.fl_addr;
  assign fl_wdata_o = r.fl_wdata;
  assign irq_o = r.irq;

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rstn_i);
  sequence enter_s(fcc_state_t s);
    r.st != s ##1 r.st == s;
  endsequence
  sequence read_end_s;
    r.st == ST_READ && r.cnt == 32'h1;
  endsequence
  read_load_a: assert property (
    read_end_s ##0 r.op == `FCC_CMD_READ |=>
      r.data == $past(fl_rdata_i) && r.done && r.st == ST_IDLE)
    else $error("single read did not load data");
  prog_time_a: assert property (
    enter_s(ST_PROG) |-> r.cnt == PROG_CYC && r.fl_en)
    else $error("program time wrong");
  erase_time_a: assert property (
    enter_s(ST_ERASE) |-> r.cnt == ERASE_CYC && r.fl_op == FOP_ERASE)
    else $error("erase time wrong");
  verify_fail_a: assert property (
    read_end_s ##0 r.op == `FCC_CMD_VERIFY ##0 fl_rdata_i != r.data |=>
      r.fail && r.done)
    else $error("verify mismatch not flagged");
  mass_time_a: assert property (
    enter_s(ST_MASS) |-> r.cnt == MASS_CYC && r.fl_op == FOP_MASS)
    else $error("mass erase time wrong");
  mass_guard_a: assert property (
    enter_s(ST_MASS) |->
      $past(r.guard) == 2'h2 && $past(r.data) == `FCC_MASS_KEY)
    else $error("mass erase without guard");
  sign_time_a: assert property (
    enter_s(ST_SIGN) |-> r.cnt == SIGN_CYC ##1 r.fl_addr == 16'h2)
    else $error("signature start wrong");
  cmd_back_a: assert property (
    r.st != ST_IDLE && n.st == ST_IDLE && r.op <= `FCC_CMD_MASS |=>
      r.cmd == `FCC_CMD_BREAD)
    else $error("command not back to burst read");
  wr_block_a: assert property (
    wdone_w && r.st == ST_IDLE && paddr_i == `FCC_A_CMD &&
    pwdata_i[7:0] == `FCC_CMD_WRITE && !wr_ok(r.addr, eff_prot_w) |=>
      r.fail && r.st == ST_IDLE)
    else $error("protected page programmed");
  stat_clear_a: assert property (
    acc_w && !pwrite_i && paddr_i == `FCC_A_STATUS && r.st == ST_IDLE &&
    !wdone_w |=> !r.done && !r.fail && !r.irqst)
    else $error("status read did not clear");
  busy_read_a: assert property (
    acc_w && !pwrite_i && paddr_i == `FCC_A_STATUS |=>
      r.prdata[`FCC_STA_BUSY] == $past(r.st != ST_IDLE) && r.pready)
    else $error("busy bit wrong");
  irq_set_a: assert property (
    !r.done ##1 r.done && $past(r.mode[`FCC_MOD_IRQEN]) |->
      r.irqst && irq_o)
    else $error("interrupt not raised");
endmodule
`default_nettype wire

// ==== test/fcc_flash_model.sv ====
// Behavioural flash array on the far side of the controller
`timescale 1ns/1ps
`default_nettype none

module fcc_flash_model #(
  parameter logic [15:0] FILL = 16'h5AC3
) (
  input wire logic mclk_i,
  input wire logic fl_en_i,
  input wire logic [1:0] fl_op_i,
  input wire logic [15:0] fl_addr_i,
  input wire logic [15:0] fl_wdata_i,
  output logic [15:0] fl_rdata_o
);
  logic [15:0] mem [0:32767];
  logic [17:0] prev_r;
  logic [15:0] junk_r;
  initial begin
    for (int i = 0; i < 32768; i++) begin
      mem[i] = FILL ^ 16'(i);
    end
    junk_r = 16'hA5A5;
  end
  // Data lines toggle outside a read so no stale word looks valid
  assign fl_rdata_o = (fl_en_i && fl_op_i == 2'h0) ?
                      mem[fl_addr_i[15:1]] : junk_r;
  always @(posedge mclk_i) begin
    junk_r <= ~junk_r;
    prev_r <= fl_en_i ? {fl_op_i, fl_addr_i} : 18'h3FFFF;
    if (fl_en_i && {fl_op_i, fl_addr_i} != prev_r) begin
      case (fl_op_i)
        // Programming only clears bits, as in a real array
        2'h1: mem[fl_addr_i[15:1]] = mem[fl_addr_i[15:1]] & fl_wdata_i;
        2'h2: for (int i = 0; i < 256; i++) mem[{fl_addr_i[15:9], 8'(i)}] = 16'hFFFF;
        2'h3: for (int i = 0; i < 31744; i++) mem[i] = 16'hFFFF;
        default: ;
      endcase
    end
  end
endmodule

`default_nettype wire

// ==== test/tb.sv ====
// Self-checking bench for the flash command controller
`timescale 1ns/1ps
`default_nettype none
`include "fcc_defines.svh"

module tb;
  import fcc_pkg::*;
  localparam logic [15:0] FILL = 16'h5AC3;
  logic mclk_i;
  logic rstn_i;
  logic psel_i, penable_i, pwrite_i, pready_o, pslverr_o, fl_en_o, irq_o;
  logic [7:0] paddr_i;
  logic [31:0] pwdata_i, prdata_o, q;
  logic [1:0] fl_op_o;
  logic [15:0] fl_addr_o, fl_wdata_o, fl_rdata_i, v;
  logic [64:0] expq[$];
  logic [64:0] note;
  logic [23:0] sg;
  int err_total = 0;
  int n_compared = 0;

  fcc_flash_command_controller #(.PROG_CYC(20), .ERASE_CYC(40),
    .MASS_CYC(60), .SIGN_CYC(40)) dut (.mclk_i(mclk_i), .rstn_i(rstn_i),
    .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
    .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o), .fl_en_o(fl_en_o),
    .fl_op_o(fl_op_o), .fl_addr_o(fl_addr_o), .fl_wdata_o(fl_wdata_o),
    .fl_rdata_i(fl_rdata_i), .irq_o(irq_o));
  fcc_flash_model #(.FILL(FILL)) flash (.mclk_i(mclk_i), .fl_en_i(fl_en_o),
    .fl_op_i(fl_op_o), .fl_addr_i(fl_addr_o), .fl_wdata_i(fl_wdata_o),
    .fl_rdata_o(fl_rdata_i));

  initial begin
    mclk_i = 1'b0;
    forever #2 mclk_i = ~mclk_i;
  end

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      err_total++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wrap_up();
    $display("Compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Takes the oldest note whenever a transfer completes
  always @(posedge mclk_i) begin
    if (psel_i && penable_i && pready_o === 1'b1 && expq.size() > 0) begin
      note = expq.pop_front();
      if (note[32:1] != 32'h0) chk("prdata", note[64:33], prdata_o & note[32:1]);
      chk("pslverr", {31'h0, note[0]}, {31'h0, pslverr_o});
    end
  end

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [31:0] e, input logic [31:0] m, input logic er);
    int n;
    n = 0;
    expq.push_back({e, m, er});
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge mclk_i);
    penable_i <= 1'b1;
    do begin
      @(posedge mclk_i);
      n++;
    end while (pready_o !== 1'b1 && n < 50);
    q = prdata_o;
    if (n >= 50) chk("pready", 32'h1, 32'h0);
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    @(posedge mclk_i);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 32'h0, 32'h0, 1'b0);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input logic [31:0] m);
    apb(1'b0, a, 32'h0, e & m, m, 1'b0);
  endtask

  task automatic wait_done(input logic f);
    int n;
    n = 0;
    do begin
      rd(`FCC_A_STATUS, 32'h0, 32'h0);
      n++;
    end while (q[0] !== 1'b1 && n < 300);
    chk("done", 32'h1, {31'h0, q[0]});
    chk("fail", {31'h0, f}, {31'h0, q[1]});
  endtask

  task automatic cmd(input logic [7:0] c, input logic f);
    wr(`FCC_A_CMD, {24'h0, c});
    wait_done(f);
  endtask

  task automatic fread(input logic [15:0] a, input logic [15:0] e);
    wr(`FCC_A_ADDR, {16'h0, a});
    cmd(`FCC_CMD_READ, 1'b0);
    rd(`FCC_A_DATA, {16'h0, e}, 32'hFFFF);
  endtask

  initial begin
    #200000;
    err_total++;
    wrap_up();
  end

  initial begin
    void'($urandom(32'h706D));
    rstn_i = 1'b0;
    psel_i = 1'b0;
    penable_i = 1'b0;
    pwrite_i = 1'b0;
    paddr_i = 8'h00;
    pwdata_i = 32'h0;
    repeat (6) @(posedge mclk_i);
    rstn_i <= 1'b1;
    @(posedge mclk_i);
    rd(`FCC_A_CMD, 32'h7, 32'hFF);
    rd(`FCC_A_PROT_P, 32'hFFFFFFFF, 32'hFFFFFFFF);
    rd(`FCC_A_PROT_H, 32'hFFFFFFFF, 32'hFFFFFFFF);
    rd(`FCC_A_MODE, 32'h0, 32'hFF);
    rd(`FCC_A_STATUS, 32'h20, 32'h2F);
    apb(1'b0, 8'h20, 32'h0, 32'h0, 32'hFFFFFFFF, 1'b1);
    wr(`FCC_A_ADDR, 32'h0100);
    cmd(`FCC_CMD_ERASE, 1'b0);
    fread(16'h0100, 16'hFFFF);
    fread(16'h0300, FILL ^ 16'h0180);
    v = 16'($urandom());
    wr(`FCC_A_ADDR, 32'h0100);
    wr(`FCC_A_DATA, {16'h0, v});
    wr(`FCC_A_CMD, {24'h0, `FCC_CMD_WRITE});
    rd(`FCC_A_STATUS, 32'h4, 32'h4);
    wr(`FCC_A_DATA, {16'h0, ~v});
    wait_done(1'b0);
    rd(`FCC_A_DATA, {16'h0, v}, 32'hFFFF);
    rd(`FCC_A_CMD, 32'h7, 32'hFF);
    fread(16'h0100, v);
    cmd(`FCC_CMD_VERIFY, 1'b0);
    wr(`FCC_A_DATA, {16'h0, ~v});
    cmd(`FCC_CMD_VERIFY, 1'b1);
    rd(`FCC_A_STATUS, 32'h0, 32'h3);
    v = 16'($urandom());
    wr(`FCC_A_DATA, {16'h0, v});
    cmd(`FCC_CMD_ERWR, 1'b0);
    fread(16'h0100, v);
    wr(`FCC_A_PROT_H, 32'hFFFFFFFE);
    cmd(`FCC_CMD_WRITE, 1'b1);
    wr(`FCC_A_PROT_H, 32'h7FFFFFFF);
    wr(`FCC_A_ADDR, 32'h0300);
    cmd(`FCC_CMD_READ, 1'b1);
    wr(`FCC_A_PROT_H, 32'hFFFFFFFF);
    wr(`FCC_A_ADDR, 32'hF800);
    cmd(`FCC_CMD_WRITE, 1'b1);
    cmd(`FCC_CMD_PROTECT, 1'b0);
    cmd(`FCC_CMD_PROTECT, 1'b1);
    cmd(`FCC_CMD_MASS, 1'b1);
    wr(`FCC_A_ADDR, 32'h0800);
    cmd(`FCC_CMD_READ, 1'b0);
    cmd(`FCC_CMD_VERIFY, 1'b0);
    wr(`FCC_A_DATA, 32'h6);
    cmd(`FCC_CMD_MASS, 1'b0);
    fread(16'h0100, 16'hFFFF);
    fread(16'hF800, FILL ^ 16'h7C00);
    cmd(`FCC_CMD_PROTECT, 1'b0);
    wr(`FCC_A_ADDR, 32'h0400);
    wr(`FCC_A_CMD, {24'h0, `FCC_CMD_BWRITE});
    rd(`FCC_A_STATUS, 32'h20, 32'h20);
    for (int i = 0; i < 8; i++) begin
      wr(`FCC_A_DATA, {16'h0, FILL ^ 16'(i)});
      wait_done(1'b0);
    end
    rd(`FCC_A_CMD, 32'h7, 32'hFF);
    for (int i = 0; i < 8; i++) begin
      fread(16'h0400 + 16'(2 * i), FILL ^ 16'(i));
    end
    wr(`FCC_A_ADDR, 32'h0602);
    wr(`FCC_A_DATA, 32'h0);
    cmd(`FCC_CMD_WRITE, 1'b0);
    wr(`FCC_A_ADDR, 32'h0600);
    wr(`FCC_A_CMD, {24'h0, `FCC_CMD_BERWR});
    rd(`FCC_A_STATUS, 32'h20, 32'h20);
    wr(`FCC_A_DATA, {16'h0, v});
    wait_done(1'b0);
    cmd(`FCC_CMD_BSTOP, 1'b0);
    rd(`FCC_A_STATUS, 32'h20, 32'h27);
    rd(`FCC_A_CMD, 32'h7, 32'hFF);
    fread(16'h0600, v);
    fread(16'h0602, 16'hFFFF);
    cmd(`FCC_CMD_SIGN, 1'b0);
    sg = 24'h0;
    repeat (40) sg = {sg[22:0], sg[23]} ^ 24'h00FFFF;
    rd(`FCC_A_SIGN, {8'h0, sg}, 32'hFFFFFFFF);
    wr(`FCC_A_CMD, 32'h0000000D);
    rd(`FCC_A_STATUS, 32'h0, 32'h27);
    wr(`FCC_A_CMD, 32'h0);
    rd(`FCC_A_CMD, 32'h7, 32'hFF);
    wr(`FCC_A_MODE, 32'h10);
    wr(`FCC_A_CMD, {24'h0, `FCC_CMD_PING});
    repeat (3) @(posedge mclk_i);
    chk("irq", 32'h1, {31'h0, irq_o});
    rd(`FCC_A_STATUS, 32'h9, 32'hB);
    chk("irq", 32'h0, {31'h0, irq_o});
    wr(`FCC_A_MODE, 32'h0);
    cmd(`FCC_CMD_PING, 1'b0);
    chk("irq", 32'h0, {31'h0, irq_o});
    wrap_up();
  end
endmodule

`default_nettype wire
